// [verilog/timer_cfg_params.svh]
// Purpose: bit positions, write masks, codes and reset values of the timer and configuration registers
// Assumes: documented bit n (msb first) sits at vector index 31-n
// Notes: definitions only
`ifndef TIMER_CFG_PARAMS_SVH
`define TIMER_CFG_PARAMS_SVH

// ----------------------------------------
// timer_control fields
// ----------------------------------------
`define TC_WP_HI 31
`define TC_WP_LO 30
`define TC_WRA_HI 29
`define TC_WRA_LO 28
`define TC_WIE 27
`define TC_DIE 26
`define TC_FP_HI 25
`define TC_FP_LO 24
`define TC_FIE 23
`define TC_ARE 22
`define TC_WPX_HI 20
`define TC_WPX_LO 17
`define TC_FPX_HI 16
`define TC_FPX_LO 13
`define TC_MASK 32'hffdfe000

// ----------------------------------------
// timer_status fields
// ----------------------------------------
`define TS_ENW 31
`define TS_WIS 30
`define TS_WRS_HI 29
`define TS_WRS_LO 28
`define TS_DIS 27
`define TS_FIS 26
`define TS_MASK 32'hfc000000

// ----------------------------------------
// implementation_control_zero fields
// ----------------------------------------
`define IC_MACHINE_CHECK_PIN_ENABLE 31
`define IC_BA_HI 25
`define IC_BA_LO 24
`define IC_DOZE 23
`define IC_NAP 22
`define IC_SLEEP 21
`define IC_ICR 17
`define IC_NHR 16
`define IC_TIME_BASE_RUN 14
`define IC_DMEE 12
`define IC_DMCE 11
`define IC_CMDE 10
`define IC_MMDE 9
`define IC_DUEN 8
`define IC_MASK 32'h83e35f00

// ----------------------------------------
// watchdog action codes and reset values
// ----------------------------------------
`define WRA_NONE 2'h0
`define WRA_CHECKSTOP 2'h1
`define WRA_RESET_OUT 2'h2
`define REG_RESET 32'h00000000

`endif

// [verilog/timer_cfg_pkg.sv]
// Purpose: types shared by the timer and configuration register bank
// Assumes: nothing beyond the params header
// Notes: no constants here, see timer_cfg_params.svh
package timer_cfg_pkg;

  typedef enum logic [1:0] {SEL_NONE, SEL_TIMER_CONTROL, SEL_TIMER_STATUS, SEL_IMPL_CONTROL} spr_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    spr_sel_t sel;
    logic [31:0] data;
  } spr_req_t;

  typedef struct packed {
    logic ext;
    logic crit;
    logic mc;
    logic debug;
  } int_taken_t;

  // time base bit i counted msb first over upper||lower
  function automatic logic tb_bit(input logic [63:0] tb, input logic [5:0] idx);
    tb_bit = tb[6'h3f - idx];
  endfunction

endpackage

// [verilog/tb_tap_edge.sv]
// Purpose: picks one time base bit by a 6-bit index and flags its rising edge
// Assumes: time base counts on mclk, same domain
// Notes: an index change can flag one false edge, as on the original tap mux
`timescale 1ns/100ps
module tb_tap_edge (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [63:0] time_base,
  input wire logic [5:0] tap_index,
  output logic rise
);
  wire logic tap_now;
  logic tap_reg;

  assign tap_now = timer_cfg_pkg::tb_bit(time_base, tap_index); // see R02
  assign rise = tap_now & ~tap_reg; // see R01

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tap_reg <= 1'b0;
    end else begin
      tap_reg <= tap_now;
    end
  end
endmodule

// [verilog/timer_cfg_regs.sv]
// Purpose: timer control, timer status and implementation control registers of the core
// Assumes: software reaches them by move-to/move-from special register requests on mclk
// Notes: outputs are registered, so each effect shows at least one cycle after its cause
//
// Operation
// R01: watchdog index is extension joined with period field; rising tap bit fires.
// R02: index zero picks upper word bit 0, all ones picks lower bit 31.
// R03: interval index built the same way; rising tap bit sets interval flag.
// R04: watchdog action code: none, checkstop, reset output low, reserved.
// R05: watchdog action resets to zero and freezes once software writes non-zero.
// R06: separate enables gate watchdog, decrementer and interval interrupts.
// R07: status records action taken on final watchdog time-out, zero means none.
// R08: status holds arm, watchdog, decrementer and interval flags at fixed bits.
// R09: status write clears only bits written as one.
// R10: bit 0 enables the external machine check pin.
// R11: branch acceleration field disables lookahead backward, forward or both.
// R12: absolute branches still use displacement msb for direction.
// R13: doze, nap, sleep bits pick the mode entered on wait enable.
// R14: bit 14 lets external and critical interrupts drop the reservation.
// R15: bit 15 is a software flag cleared by every reset.
// R16: bit 17 runs the time base.
// R17: bits 19 and 20 let debug interrupts clear external and critical enables.
// R18: bit 21 lets critical and watchdog interrupts clear debug enable.
// R19: bit 22 lets machine check interrupts clear debug enable.
// R20: critical debug events raise debug event and clear saved debug enable.
// R21: bit 23 picks debug save pair and return, else critical pair.
// R22: with debug unit off, the four clearing bits act as ones.
// R23: reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`include "timer_cfg_params.svh"
module timer_cfg_regs (
  input wire logic mclk,
  input wire logic nrst,
  input wire timer_cfg_pkg::spr_req_t spr_req,
  output logic [31:0] spr_rdata,
  input wire logic [63:0] time_base,
  input wire logic dec_event,
  input wire logic mcp_pin_n,
  input wire logic branch_valid,
  input wire logic branch_disp_msb,
  input wire logic wait_enable,
  input wire timer_cfg_pkg::int_taken_t int_taken,
  input wire logic critical_debug_event_enable,
  input wire logic debug_int_enable,
  output logic watchdog_irq,
  output logic decrementer_irq,
  output logic interval_irq,
  output logic checkstop,
  output logic reset_out_n,
  output logic machine_check_req,
  output logic branch_accel_allow,
  output logic doze_req,
  output logic nap_req,
  output logic sleep_req,
  output logic clear_reservation,
  output logic time_base_run,
  output logic auto_reload_enable,
  output logic clear_external_int_enable,
  output logic clear_critical_int_enable,
  output logic clear_debug_int_enable,
  output logic debug_event_req,
  output logic clear_saved_debug_enable,
  output logic use_debug_save_restore_pair,
  output logic debug_return_illegal
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [31:0] timer_control_reg, timer_control_next;
  logic [31:0] timer_status_reg, timer_status_next;
  logic [31:0] impl_control_reg, impl_control_next;
  logic mcp_meta_reg, mcp_sync_reg;

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  wire logic wr_tc = spr_req.wr && spr_req.sel == timer_cfg_pkg::SEL_TIMER_CONTROL;
  wire logic wr_ts = spr_req.wr && spr_req.sel == timer_cfg_pkg::SEL_TIMER_STATUS;
  wire logic wr_ic = spr_req.wr && spr_req.sel == timer_cfg_pkg::SEL_IMPL_CONTROL;
  wire logic [31:0] rd_mux;

  assign rd_mux = (spr_req.sel == timer_cfg_pkg::SEL_TIMER_CONTROL) ? timer_control_reg :
                  (spr_req.sel == timer_cfg_pkg::SEL_TIMER_STATUS) ? timer_status_reg :
                  (spr_req.sel == timer_cfg_pkg::SEL_IMPL_CONTROL) ? impl_control_reg : 32'h00000000;

  // ----------------------------------------
  // time base taps
  // ----------------------------------------
  wire logic [1:0] wra = timer_control_reg[`TC_WRA_HI:`TC_WRA_LO];
  wire logic [5:0] tap_idx [2];
  wire logic [1:0] tap_rise;
  wire logic wd_rise = tap_rise[0];
  wire logic fit_rise = tap_rise[1];

  assign tap_idx[0] = {timer_control_reg[`TC_WPX_HI:`TC_WPX_LO], timer_control_reg[`TC_WP_HI:`TC_WP_LO]}; // see R01
  assign tap_idx[1] = {timer_control_reg[`TC_FPX_HI:`TC_FPX_LO], timer_control_reg[`TC_FP_HI:`TC_FP_LO]}; // see R03

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_tap
      tb_tap_edge u_tap (
        .mclk(mclk),
        .nrst(nrst),
        .time_base(time_base),
        .tap_index(tap_idx[g]),
        .rise(tap_rise[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // watchdog progression
  // ----------------------------------------
  // first expiry arms, second raises the interrupt, third is the final time-out
  wire logic wd_arm = wd_rise && !timer_status_reg[`TS_ENW];
  wire logic wd_int = wd_rise && timer_status_reg[`TS_ENW] && !timer_status_reg[`TS_WIS];
  wire logic wd_final = wd_rise && timer_status_reg[`TS_ENW] && timer_status_reg[`TS_WIS];
  wire logic wd_record = wd_final && timer_status_reg[`TS_WRS_HI:`TS_WRS_LO] == `WRA_NONE;

  // ----------------------------------------
  // next values
  // ----------------------------------------
  wire logic [31:0] ts_set;
  wire logic [31:0] ts_clr;

  assign ts_set = ({31'h0, wd_arm} << `TS_ENW) | ({31'h0, wd_int} << `TS_WIS) | // see R08
                  ({31'h0, dec_event} << `TS_DIS) | ({31'h0, fit_rise} << `TS_FIS); // see R03
  assign ts_clr = wr_ts ? (spr_req.data & `TS_MASK) : 32'h00000000; // see R09

  always_comb begin
    timer_control_next = wr_tc ? (spr_req.data & `TC_MASK) : timer_control_reg; // see R23
    // once non-zero the action field ignores software
    if (wra != `WRA_NONE) begin
      timer_control_next[`TC_WRA_HI:`TC_WRA_LO] = wra; // see R05
    end
    // a flag set in the same cycle as its clear survives
    timer_status_next = (timer_status_reg & ~ts_clr) | ts_set; // see R09
    if (wd_record) begin
      timer_status_next[`TS_WRS_HI:`TS_WRS_LO] = wra; // see R07
    end
    impl_control_next = wr_ic ? (spr_req.data & `IC_MASK) : impl_control_reg; // see R23
  end

  // ----------------------------------------
  // debug unit gating of the clearing bits
  // ----------------------------------------
  wire logic dbg_on = impl_control_reg[`IC_DUEN];
  wire logic eff_dmee = !dbg_on || impl_control_reg[`IC_DMEE]; // see R22
  wire logic eff_dmce = !dbg_on || impl_control_reg[`IC_DMCE]; // see R22
  wire logic eff_cmde = !dbg_on || impl_control_reg[`IC_CMDE]; // see R22
  wire logic eff_mmde = !dbg_on || impl_control_reg[`IC_MMDE]; // see R22
  wire logic crit_dbg_evt = (int_taken.crit || int_taken.mc) && critical_debug_event_enable && debug_int_enable;

  // branch direction comes from displacement msb even for absolute targets
  wire logic [1:0] accel = impl_control_reg[`IC_BA_HI:`IC_BA_LO];
  wire logic accel_block = branch_disp_msb ? accel[0] : accel[1]; // see R11 see R12

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      timer_control_reg <= `REG_RESET; // see R05
      timer_status_reg <= `REG_RESET;
      impl_control_reg <= `REG_RESET; // see R15
      spr_rdata <= 32'h00000000;
    end else begin
      timer_control_reg <= timer_control_next;
      timer_status_reg <= timer_status_next;
      impl_control_reg <= impl_control_next;
      spr_rdata <= spr_req.rd ? rd_mux : spr_rdata;
    end
  end

  // pin synchroniser; only the second stage feeds logic
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mcp_meta_reg <= 1'b0;
      mcp_sync_reg <= 1'b0;
    end else begin
      mcp_meta_reg <= ~mcp_pin_n;
      mcp_sync_reg <= mcp_meta_reg;
    end
  end

  // the final time-out actions hold until the next core reset
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      checkstop <= 1'b0;
      reset_out_n <= 1'b1;
    end else begin
      checkstop <= checkstop || (wd_final && wra == `WRA_CHECKSTOP); // see R04
      reset_out_n <= reset_out_n && !(wd_final && wra == `WRA_RESET_OUT); // see R04
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      watchdog_irq <= 1'b0;
      decrementer_irq <= 1'b0;
      interval_irq <= 1'b0;
      machine_check_req <= 1'b0;
      branch_accel_allow <= 1'b0;
      doze_req <= 1'b0;
      nap_req <= 1'b0;
      sleep_req <= 1'b0;
      time_base_run <= 1'b0;
      auto_reload_enable <= 1'b0;
    end else begin
      watchdog_irq <= timer_status_reg[`TS_WIS] && timer_control_reg[`TC_WIE]; // see R06
      decrementer_irq <= timer_status_reg[`TS_DIS] && timer_control_reg[`TC_DIE]; // see R06
      interval_irq <= timer_status_reg[`TS_FIS] && timer_control_reg[`TC_FIE]; // see R06
      machine_check_req <= mcp_sync_reg && impl_control_reg[`IC_MACHINE_CHECK_PIN_ENABLE]; // see R10
      branch_accel_allow <= branch_valid && !accel_block; // see R11
      doze_req <= wait_enable && impl_control_reg[`IC_DOZE]; // see R13
      nap_req <= wait_enable && impl_control_reg[`IC_NAP]; // see R13
      sleep_req <= wait_enable && impl_control_reg[`IC_SLEEP]; // see R13
      time_base_run <= impl_control_reg[`IC_TIME_BASE_RUN]; // see R16
      auto_reload_enable <= timer_control_reg[`TC_ARE];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clear_reservation <= 1'b0;
      clear_external_int_enable <= 1'b0;
      clear_critical_int_enable <= 1'b0;
      clear_debug_int_enable <= 1'b0;
      debug_event_req <= 1'b0;
      clear_saved_debug_enable <= 1'b0;
      use_debug_save_restore_pair <= 1'b0;
      debug_return_illegal <= 1'b1;
    end else begin
      clear_reservation <= (int_taken.ext || int_taken.crit) && impl_control_reg[`IC_ICR]; // see R14
      clear_external_int_enable <= int_taken.debug && eff_dmee; // see R17
      clear_critical_int_enable <= int_taken.debug && eff_dmce; // see R17
      clear_debug_int_enable <= (int_taken.crit && eff_cmde) || (int_taken.mc && eff_mmde); // see R18 see R19
      debug_event_req <= crit_dbg_evt; // see R20
      clear_saved_debug_enable <= crit_dbg_evt; // see R20
      use_debug_save_restore_pair <= dbg_on; // see R21
      debug_return_illegal <= !dbg_on; // see R21
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_action_frozen: // see R05
    assert property (wra != `WRA_NONE |=> $stable(wra))
    else $error("watchdog action changed after being set");

  a_status_w1c: // see R09
    assert property (wr_ts && spr_req.data[`TS_DIS] && !dec_event |=> !timer_status_reg[`TS_DIS])
    else $error("written one did not clear decrementer flag");

  a_status_set_wins: // see R09
    assert property (wr_ts && spr_req.data[`TS_FIS] && fit_rise |=> timer_status_reg[`TS_FIS])
    else $error("interval flag lost against a clear");

  a_wd_arm_first: // see R01
    assert property (wd_rise && !timer_status_reg[`TS_ENW] |=> timer_status_reg[`TS_ENW] && !$past(wd_int))
    else $error("watchdog expiry did not arm");

  a_wd_irq_gate: // see R06
    assert property (timer_status_reg[`TS_WIS] && timer_control_reg[`TC_WIE] |=> watchdog_irq)
    else $error("enabled watchdog flag gave no interrupt");

  a_wrs_record: // see R07
    assert property (wd_record |=> timer_status_reg[`TS_WRS_HI:`TS_WRS_LO] == $past(wra))
    else $error("final time-out not recorded");

  a_reset_out: // see R04
    assert property (wd_final && wra == `WRA_RESET_OUT |=> !reset_out_n ##1 !reset_out_n)
    else $error("reset output not asserted on final time-out");

  a_dbg_off_mask: // see R22
    assert property (int_taken.debug && !dbg_on |=> clear_external_int_enable && clear_critical_int_enable)
    else $error("debug unit off did not force enable clears");

  a_resv_kept: // see R14
    assert property (int_taken.ext && !impl_control_reg[`IC_ICR] |=> !clear_reservation)
    else $error("reservation dropped with bit 14 clear");

  a_reserved_zero: // see R23
    assert property (wr_ic |=> (impl_control_reg & ~`IC_MASK) == 32'h00000000)
    else $error("reserved control bit became set");

endmodule

// [test/tb_timer_cfg_regs.sv]
// Purpose: self-checking bench for the timer control, timer status and implementation control registers
// Assumes: inputs change on the falling edge of mclk; outputs are settled by the next falling edge
// Notes: every expected value is built from the field layout, not read back from the design
`timescale 1ns/100ps
`include "timer_cfg_params.svh"
module tb_timer_cfg_regs;
  logic mclk, nrst;
  timer_cfg_pkg::spr_req_t spr_req;
  logic [31:0] spr_rdata;
  logic [63:0] time_base;
  logic dec_event, mcp_pin_n, branch_valid, branch_disp_msb, wait_enable;
  timer_cfg_pkg::int_taken_t int_taken;
  logic critical_debug_event_enable, debug_int_enable;
  logic watchdog_irq, decrementer_irq, interval_irq, checkstop, reset_out_n, machine_check_req;
  logic branch_accel_allow, doze_req, nap_req, sleep_req, clear_reservation, time_base_run;
  logic auto_reload_enable, clear_external_int_enable, clear_critical_int_enable, clear_debug_int_enable;
  logic debug_event_req, clear_saved_debug_enable, use_debug_save_restore_pair, debug_return_illegal;
  int errors, n_tests;

  timer_cfg_regs uut (.mclk, .nrst, .spr_req, .spr_rdata, .time_base, .dec_event, .mcp_pin_n, .branch_valid,
    .branch_disp_msb, .wait_enable, .int_taken, .critical_debug_event_enable, .debug_int_enable, .watchdog_irq,
    .decrementer_irq, .interval_irq, .checkstop, .reset_out_n, .machine_check_req, .branch_accel_allow,
    .doze_req, .nap_req, .sleep_req, .clear_reservation, .time_base_run, .auto_reload_enable,
    .clear_external_int_enable, .clear_critical_int_enable, .clear_debug_int_enable, .debug_event_req,
    .clear_saved_debug_enable, .use_debug_save_restore_pair, .debug_return_illegal);

  // ----------------------------------------
  // clock, closing and watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // the tests need well under 2000 cycles; ten times that means a hang
  initial begin
    #80000;
    errors++;
    wrap_up();
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    nrst = 1'b0;
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
  endtask

  // an idle cycle follows each access so the request is never driven twice in one step
  task automatic wr(input timer_cfg_pkg::spr_sel_t sel, input logic [31:0] data);
    spr_req = '{wr: 1'b1, rd: 1'b0, sel: sel, data: data};
    @(negedge mclk);
    spr_req = '0;
    @(negedge mclk);
  endtask

  task automatic rd(input timer_cfg_pkg::spr_sel_t sel, input logic [31:0] exp);
    spr_req = '{wr: 1'b0, rd: 1'b1, sel: sel, data: 32'h0};
    @(negedge mclk);
    spr_req = '0;
    @(negedge mclk);
    check(spr_rdata, exp);
  endtask

  // one clean 0 to 1 to 0 cycle of a single time base bit
  task automatic rise(input int b);
    time_base[b] = 1'b1;
    repeat (3) @(negedge mclk);
    time_base = 64'h0;
    repeat (3) @(negedge mclk);
  endtask

  // result order: reservation, external, critical, debug enable clears, debug event, saved enable clear
  task automatic take_int(input logic [3:0] kind, input logic [5:0] exp);
    int_taken = timer_cfg_pkg::int_taken_t'(kind);
    @(negedge mclk);
    int_taken = '0;
    check(32'({clear_reservation, clear_external_int_enable, clear_critical_int_enable, clear_debug_int_enable,
      debug_event_req, clear_saved_debug_enable}), 32'(exp));
    @(negedge mclk);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    spr_req = '0;
    time_base = 64'h0;
    int_taken = '0;
    {dec_event, branch_valid, branch_disp_msb, wait_enable} = 4'h0;
    mcp_pin_n = 1'b1;
    critical_debug_event_enable = 1'b1;
    debug_int_enable = 1'b1;
    errors = 0;
    n_tests = 0;
    do_reset();
    rd(timer_cfg_pkg::SEL_TIMER_CONTROL, `REG_RESET);
    rd(timer_cfg_pkg::SEL_TIMER_STATUS, `REG_RESET);
    check(32'({reset_out_n, debug_return_illegal, checkstop}), 32'h6);
    wr(timer_cfg_pkg::SEL_TIMER_CONTROL, 32'hcfffffff);
    rd(timer_cfg_pkg::SEL_TIMER_CONTROL, 32'hcfdfe000);
    check(32'(auto_reload_enable), 32'h1);
    wr(timer_cfg_pkg::SEL_TIMER_CONTROL, 32'h0);
    rd(timer_cfg_pkg::SEL_TIMER_CONTROL, 32'h0);
    // decrementer flag set by its event, cleared only by a written one
    wr(timer_cfg_pkg::SEL_TIMER_CONTROL, 32'h04000000);
    dec_event = 1'b1;
    @(negedge mclk);
    dec_event = 1'b0;
    rd(timer_cfg_pkg::SEL_TIMER_STATUS, 32'h08000000);
    check(32'(decrementer_irq), 32'h1);
    wr(timer_cfg_pkg::SEL_TIMER_STATUS, 32'hf3ffffff);
    rd(timer_cfg_pkg::SEL_TIMER_STATUS, 32'h08000000);
    wr(timer_cfg_pkg::SEL_TIMER_STATUS, 32'h08000000);
    rd(timer_cfg_pkg::SEL_TIMER_STATUS, 32'h0);
    check(32'(decrementer_irq), 32'h0);
    // all-ones interval index taps the last bit of the lower word
    wr(timer_cfg_pkg::SEL_TIMER_CONTROL, 32'h0381e000);
    rise(0);
    rd(timer_cfg_pkg::SEL_TIMER_STATUS, 32'h04000000);
    check(32'(interval_irq), 32'h1);
    // a tap rise in the same cycle as its write-one clear keeps the flag
    time_base[0] = 1'b1;
    wr(timer_cfg_pkg::SEL_TIMER_STATUS, 32'h04000000);
    time_base = 64'h0;
    rd(timer_cfg_pkg::SEL_TIMER_STATUS, 32'h04000000);
    // watchdog index zero taps upper bit 0; interval index zero shares it
    for (int k = 0; k < 3; k++) begin
      do_reset();
      wr(timer_cfg_pkg::SEL_TIMER_CONTROL, 32'h08000000 | (32'(k) << 28));
      rise(63);
      rd(timer_cfg_pkg::SEL_TIMER_STATUS, 32'h84000000);
      rise(63);
      rd(timer_cfg_pkg::SEL_TIMER_STATUS, 32'hc4000000);
      check(32'(watchdog_irq), 32'h1);
      rise(63);
      rd(timer_cfg_pkg::SEL_TIMER_STATUS, 32'hc4000000 | (32'(k) << 28));
      check(32'({checkstop, reset_out_n}), {30'h0, k == 1, k != 2});
      wr(timer_cfg_pkg::SEL_TIMER_CONTROL, 32'h20000000);
      rd(timer_cfg_pkg::SEL_TIMER_CONTROL, k == 0 ? 32'h20000000 : 32'(k) << 28);
      wr(timer_cfg_pkg::SEL_TIMER_STATUS, 32'h40000000);
      rd(timer_cfg_pkg::SEL_TIMER_STATUS, 32'h84000000 | (32'(k) << 28));
    end
    // implementation control: every writable bit set, then reset clears it all
    do_reset();
    wr(timer_cfg_pkg::SEL_IMPL_CONTROL, 32'hffffffff);
    rd(timer_cfg_pkg::SEL_IMPL_CONTROL, 32'h83e35f00);
    wait_enable = 1'b1;
    mcp_pin_n = 1'b0;
    repeat (4) @(negedge mclk);
    check(32'({machine_check_req, doze_req, nap_req, sleep_req}), 32'hf);
    check(32'({time_base_run, use_debug_save_restore_pair, debug_return_illegal}), 32'h6);
    do_reset();
    rd(timer_cfg_pkg::SEL_IMPL_CONTROL, 32'h0);
    check(32'({machine_check_req, doze_req, nap_req, sleep_req}), 32'h0);
    check(32'({time_base_run, use_debug_save_restore_pair, debug_return_illegal}), 32'h1);
    wr(timer_cfg_pkg::SEL_IMPL_CONTROL, 32'h00010000);
    rd(timer_cfg_pkg::SEL_IMPL_CONTROL, 32'h00010000);
    // branch lookahead for every control code and both directions
    branch_valid = 1'b1;
    for (int c = 0; c < 4; c++) begin
      for (int d = 0; d < 2; d++) begin
        wr(timer_cfg_pkg::SEL_IMPL_CONTROL, 32'(c) << 24);
        branch_disp_msb = d[0];
        repeat (2) @(negedge mclk);
        check(32'(branch_accel_allow), 32'(!((c[0] && d == 1) || (c[1] && d == 0))));
      end
    end
    // debug unit on: only the selected clears act
    wr(timer_cfg_pkg::SEL_IMPL_CONTROL, 32'h00021100);
    take_int(4'h8, 6'h20);
    take_int(4'h4, 6'h23);
    take_int(4'h2, 6'h03);
    take_int(4'h1, 6'h10);
    // debug unit off: the four clear bits behave as ones
    critical_debug_event_enable = 1'b0;
    wr(timer_cfg_pkg::SEL_IMPL_CONTROL, 32'h0);
    take_int(4'h8, 6'h00);
    take_int(4'h4, 6'h04);
    take_int(4'h2, 6'h04);
    take_int(4'h1, 6'h18);
    wrap_up();
  end
endmodule
